// file: hw/tcg_pkg.sv
/*
  Shared constants and types of the gated 16-bit timer/counter: register
  offsets, field images, reset values, source codes and timing counts.
  Assumes a 100 MHz system clock and a byte-addressed APB with 32-bit data.
*/
package tcg_pkg;

  // Register byte offsets
  localparam logic [7:0] TCG_OFF_CONTROL = 8'h00;
  localparam logic [7:0] TCG_OFF_GATE    = 8'h04;
  localparam logic [7:0] TCG_OFF_LOW     = 8'h08;
  localparam logic [7:0] TCG_OFF_HIGH    = 8'h0c;
  localparam logic [7:0] TCG_OFF_STATUS  = 8'h10;

  // Reset values and the count maximum
  localparam logic [7:0]  TCG_CONTROL_RESET = 8'h00;
  localparam logic [7:0]  TCG_GATE_RESET    = 8'h00;
  localparam logic [15:0] TCG_COUNT_RESET   = 16'h0000;
  localparam logic [15:0] TCG_COUNT_MAX     = 16'hffff;

  // Status register fields
  localparam int TCG_STAT_FLAG_BIT = 0;
  localparam int TCG_STAT_IE_BIT   = 1;

  // Gate register field positions: go for software writes, value for readback only
  localparam int TCG_GATE_GO_BIT  = 3;
  localparam int TCG_GATE_VAL_BIT = 2;

  // Instruction clock is the system clock divided down
  localparam int TCG_CLOCK_PERIOD_NS = 10;
  localparam int TCG_INSTR_PERIOD_NS = 40;
  localparam int TCG_INSTR_CYCLES    = TCG_INSTR_PERIOD_NS / TCG_CLOCK_PERIOD_NS;
  localparam logic [1:0] TCG_INSTR_LAST = 2'(TCG_INSTR_CYCLES - 1);

  typedef enum logic [1:0] {
    TCG_SRC_INSTR = 2'b00,
    TCG_SRC_SYS   = 2'b01,
    TCG_SRC_EXT   = 2'b10,
    TCG_SRC_RSVD  = 2'b11
  } tcg_source_type;

  typedef enum logic [1:0] {
    TCG_GSRC_PIN   = 2'b00,
    TCG_GSRC_MATCH = 2'b01,
    TCG_GSRC_CMP1  = 2'b10,
    TCG_GSRC_CMP2  = 2'b11
  } tcg_gate_source_type;

  typedef enum logic [1:0] {
    TCG_PULSE_IDLE  = 2'b00,
    TCG_PULSE_ARMED = 2'b01,
    TCG_PULSE_OPEN  = 2'b10
  } tcg_pulse_state_type;

  typedef struct packed {
    tcg_source_type count_source_select;
    logic [1:0]     input_prescale_select;
    logic           lowpower_osc_enable;
    logic           external_sync_bypass;
    logic           wide_access_mode;
    logic           timer_on;
  } tcg_control_type;

  typedef struct packed {
    logic                gate_enable;
    logic                gate_polarity;
    logic                gate_toggle_mode;
    logic                gate_single_pulse_mode;
    logic                pulse_go_done;
    logic                gate_value;
    tcg_gate_source_type gate_source_select;
  } tcg_gate_type;

endpackage

// file: hw/tcg_timer.sv
/*
  Gated 16-bit timer/counter with APB register access, clock source
  selection, prescaler, gate logic with toggle and single-pulse modes.
  Assumes one 100 MHz clock, synchronous active-low reset, pins arriving
  asynchronously and on-chip gate sources on the same clock.
*/
module tcg_timer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device pins
  input  wire logic        external_count_pin,
  input  wire logic        osc_input_pin,
  input  wire logic        osc_output_pin,
  input  wire logic        gate_pin,
  output logic      [1:0]  osc_pin_oe_n,
  output logic      [1:0]  osc_pin_read,
  output logic             osc_amp_enable,
  // On-chip neighbours
  input  wire logic        companion_period_match,
  input  wire logic        comparator1_out,
  input  wire logic        comparator2_out,
  input  wire logic        special_event_trigger,
  input  wire logic [1:0]  port_direction_bits,
  output logic             overflow_irq
);

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a == off);
  endfunction

  function automatic logic [2:0] prescale_mask(input logic [1:0] sel);
    prescale_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // Registers
  tcg_pkg::tcg_control_type     ctrl_reg;
  tcg_pkg::tcg_gate_type        gcfg_reg;
  tcg_pkg::tcg_pulse_state_type pulse_reg;
  tcg_pkg::tcg_pulse_state_type pulse_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  high_buf_reg;
  logic [2:0]  pre_reg;
  logic [1:0]  phase_reg;
  logic        flag_reg;
  logic        irq_en_reg;
  logic        toggle_reg;
  logic        gate_prev_reg;
  logic        ext_armed_reg;
  logic        ext_prev_reg;
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        ext_s3_reg;

  // Bus decode
  wire wr_en   = psel & penable & pwrite;
  wire rd_en   = psel & penable & ~pwrite;
  wire wr_ctrl = wr_en & addr_hit(paddr, tcg_pkg::TCG_OFF_CONTROL);
  wire wr_gate = wr_en & addr_hit(paddr, tcg_pkg::TCG_OFF_GATE);
  wire wr_low  = wr_en & addr_hit(paddr, tcg_pkg::TCG_OFF_LOW);
  wire wr_high = wr_en & addr_hit(paddr, tcg_pkg::TCG_OFF_HIGH);
  wire wr_stat = wr_en & addr_hit(paddr, tcg_pkg::TCG_OFF_STATUS);
  wire rd_low  = rd_en & addr_hit(paddr, tcg_pkg::TCG_OFF_LOW);
  wire mapped  = addr_hit(paddr, tcg_pkg::TCG_OFF_CONTROL)
               | addr_hit(paddr, tcg_pkg::TCG_OFF_GATE)
               | addr_hit(paddr, tcg_pkg::TCG_OFF_LOW)
               | addr_hit(paddr, tcg_pkg::TCG_OFF_HIGH)
               | addr_hit(paddr, tcg_pkg::TCG_OFF_STATUS);

  // Pin synchronisers: first stage feeds only the second
  wire [3:0] pins_raw = {gate_pin, osc_output_pin, osc_input_pin, external_count_pin};
  wire gate_pin_s = sync2_reg[3];
  wire osco_s     = sync2_reg[2];
  wire osci_s     = sync2_reg[1];
  wire cki_s      = sync2_reg[0];

  wire wide     = ctrl_reg.wide_access_mode;
  wire on       = ctrl_reg.timer_on;
  wire osc_en   = ctrl_reg.lowpower_osc_enable;
  wire ext_mode = (ctrl_reg.count_source_select == tcg_pkg::TCG_SRC_EXT);
  wire bypass   = ext_mode & ctrl_reg.external_sync_bypass;

  // External source: crystal when oscillator on, else count pin
  wire ext_src   = osc_en ? osci_s : cki_s;
  // Synchronised path adds one alignment stage; bypass saves the latency
  wire ext_lvl   = bypass ? ext_src : ext_s3_reg;
  wire ext_rise  = ext_lvl & ~ext_prev_reg;
  wire ext_fall  = ~ext_lvl & ext_prev_reg;
  wire count_wr  = wr_low | wr_high;
  wire ext_tick  = ext_rise & ext_armed_reg;
  wire instr_tick = (phase_reg == tcg_pkg::TCG_INSTR_LAST);

  // Clock source selection
  logic src_tick;
  always_comb begin
    case (ctrl_reg.count_source_select)
      tcg_pkg::TCG_SRC_INSTR: src_tick = instr_tick;
      tcg_pkg::TCG_SRC_SYS:   src_tick = 1'b1;
      tcg_pkg::TCG_SRC_EXT:   src_tick = ext_tick;
      default:                src_tick = 1'b0;
    endcase
  end

  // Gate source and polarity
  logic gate_src;
  always_comb begin
    case (gcfg_reg.gate_source_select)
      tcg_pkg::TCG_GSRC_PIN:   gate_src = gate_pin_s;
      tcg_pkg::TCG_GSRC_MATCH: gate_src = companion_period_match;
      tcg_pkg::TCG_GSRC_CMP1:  gate_src = comparator1_out;
      tcg_pkg::TCG_GSRC_CMP2:  gate_src = comparator2_out;
      default:                 gate_src = 1'b0;
    endcase
  end
  wire gate_act  = gcfg_reg.gate_polarity ? gate_src : ~gate_src;
  wire gate_rise = gate_act & ~gate_prev_reg;
  wire gate_fall = ~gate_act & gate_prev_reg;
  wire pulse_open = (pulse_reg == tcg_pkg::TCG_PULSE_OPEN);
  wire pulse_go   = (pulse_reg != tcg_pkg::TCG_PULSE_IDLE);
  wire gate_qual  = gcfg_reg.gate_single_pulse_mode ? pulse_open
                  : gcfg_reg.gate_toggle_mode ? toggle_reg : gate_act;
  wire count_en   = on & (~gcfg_reg.gate_enable | gate_qual);

  // Prescaler
  wire       gated_tick = src_tick & count_en;
  wire [2:0] pmask      = prescale_mask(ctrl_reg.input_prescale_select);
  wire       pre_tick   = gated_tick & ((pre_reg & pmask) == pmask);
  wire [2:0] pre_next   = (wr_low | ~on) ? 3'h0
                        : pre_tick ? 3'h0
                        : gated_tick ? pre_reg + 3'h1 : pre_reg;

  // Counter load and increment, trigger first
  wire trig_reset = special_event_trigger & ~bypass;
  wire high_direct = wr_high & ~wide;
  wire count_load  = trig_reset | wr_low | high_direct;
  wire wrap        = pre_tick & ~count_load & (count_reg == tcg_pkg::TCG_COUNT_MAX);
  always_comb begin
    if (trig_reset)
      count_next = tcg_pkg::TCG_COUNT_RESET;
    else if (wr_low)
      count_next = {wide ? high_buf_reg : count_reg[15:8], pwdata[7:0]};
    else if (high_direct)
      count_next = {pwdata[7:0], count_reg[7:0]};
    else if (pre_tick)
      count_next = count_reg + 16'h0001;
    else
      count_next = count_reg;
  end

  // Single-pulse acquisition
  wire go_set = wr_gate & pwdata[tcg_pkg::TCG_GATE_GO_BIT] & pwdata[4];
  always_comb begin
    pulse_next = pulse_reg;
    case (pulse_reg)
      tcg_pkg::TCG_PULSE_IDLE: begin
        if (go_set)
          pulse_next = tcg_pkg::TCG_PULSE_ARMED;
      end
      tcg_pkg::TCG_PULSE_ARMED: begin
        if (gate_rise)
          pulse_next = tcg_pkg::TCG_PULSE_OPEN;
      end
      tcg_pkg::TCG_PULSE_OPEN: begin
        if (gate_fall)
          pulse_next = tcg_pkg::TCG_PULSE_IDLE;
      end
      default: pulse_next = tcg_pkg::TCG_PULSE_IDLE;
    endcase
    if (!gcfg_reg.gate_single_pulse_mode)
      pulse_next = tcg_pkg::TCG_PULSE_IDLE;
  end

  // Register readback
  wire [7:0] gate_rd = {gcfg_reg[7:4], pulse_go, gate_qual, gcfg_reg[1:0]};
  logic [7:0] rd_byte;
  always_comb begin
    case (paddr)
      tcg_pkg::TCG_OFF_CONTROL: rd_byte = ctrl_reg;
      tcg_pkg::TCG_OFF_GATE:    rd_byte = gate_rd;
      tcg_pkg::TCG_OFF_LOW:     rd_byte = count_reg[7:0];
      tcg_pkg::TCG_OFF_HIGH:    rd_byte = wide ? high_buf_reg : count_reg[15:8];
      tcg_pkg::TCG_OFF_STATUS:  rd_byte = {6'h00, irq_en_reg, flag_reg};
      default:                  rd_byte = 8'h00;
    endcase
  end
  assign prdata  = {24'h000000, rd_byte};
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Oscillator pins and overflow interrupt
  assign osc_amp_enable = osc_en;
  assign osc_pin_oe_n   = osc_en ? 2'b11 : port_direction_bits;
  assign osc_pin_read   = osc_en ? 2'b00 : {osci_s, osco_s};
  assign overflow_irq   = flag_reg & irq_en_reg;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sync1_reg  <= 4'h0;
      sync2_reg  <= 4'h0;
      ext_s3_reg <= 1'b0;
    end else begin
      sync1_reg  <= pins_raw;
      sync2_reg  <= sync1_reg;
      ext_s3_reg <= ext_src;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      ctrl_reg <= tcg_pkg::TCG_CONTROL_RESET;
      gcfg_reg <= tcg_pkg::TCG_GATE_RESET;
    end else begin
      if (wr_ctrl)
        ctrl_reg <= pwdata[7:0];
      if (wr_gate)
        gcfg_reg <= {pwdata[7:4], 2'b00, pwdata[1:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      count_reg    <= tcg_pkg::TCG_COUNT_RESET;
      high_buf_reg <= 8'h00;
      pre_reg      <= 3'h0;
      phase_reg    <= 2'h0;
    end else begin
      count_reg <= count_next;
      pre_reg   <= pre_next;
      phase_reg <= instr_tick ? 2'h0 : phase_reg + 2'h1;
      if (wide & wr_high)
        high_buf_reg <= pwdata[7:0];
      else if (wide & rd_low)
        high_buf_reg <= count_reg[15:8];
    end
  end

  // Set beats a same-cycle write-one clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flag_reg   <= 1'b0;
      irq_en_reg <= 1'b0;
    end else begin
      flag_reg <= wrap | (flag_reg & ~(wr_stat & pwdata[tcg_pkg::TCG_STAT_FLAG_BIT]));
      if (wr_stat)
        irq_en_reg <= pwdata[tcg_pkg::TCG_STAT_IE_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pulse_reg     <= tcg_pkg::TCG_PULSE_IDLE;
      toggle_reg    <= 1'b0;
      // Idle gate after reset is active (low polarity, low source): no false edge
      gate_prev_reg <= 1'b1;
      ext_prev_reg  <= 1'b0;
      ext_armed_reg <= 1'b0;
    end else begin
      pulse_reg     <= pulse_next;
      gate_prev_reg <= gate_act;
      ext_prev_reg  <= ext_lvl;
      toggle_reg    <= gcfg_reg.gate_toggle_mode & (toggle_reg ^ gate_rise);
      // Any count write (low or high byte) or stop demands a fresh falling edge
      if (count_wr | ~on)
        ext_armed_reg <= 1'b0;
      else if (ext_fall)
        ext_armed_reg <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence sys_plain_s;
    on && !gcfg_reg.gate_enable && !count_load
      && ctrl_reg.count_source_select == tcg_pkg::TCG_SRC_SYS;
  endsequence

  sequence low_write_s;
    wr_low;
  endsequence

  sys_rate_a: assert property (
    sys_plain_s and (ctrl_reg.input_prescale_select == 2'b00)
    |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("system clock source did not count every cycle");

  instr_rate_a: assert property (
    (pre_tick && ctrl_reg.count_source_select == tcg_pkg::TCG_SRC_INSTR)
    |=> (!pre_tick || ctrl_reg.count_source_select != tcg_pkg::TCG_SRC_INSTR) [*3])
    else $error("instruction clock counted faster than one in four");

  prescale_eight_a: assert property (
    (pre_tick && ctrl_reg.input_prescale_select == 2'b11 && !wr_ctrl)
    |=> (!pre_tick || ctrl_reg.input_prescale_select != 2'b11) [*7])
    else $error("divide by eight ticked early");

  timer_off_hold_a: assert property (
    (!on && !count_load) |=> $stable(count_reg))
    else $error("count moved while timer off");

  gate_block_a: assert property (
    (on && gcfg_reg.gate_enable && !gate_qual && !count_load) |=> $stable(count_reg))
    else $error("count moved with gate closed");

  toggle_clear_a: assert property (
    !gcfg_reg.gate_toggle_mode |=> !toggle_reg)
    else $error("toggle flop not cleared");

  go_clear_a: assert property (
    !gcfg_reg.gate_single_pulse_mode |=> !pulse_go)
    else $error("go bit survived leaving single pulse mode");

  ext_arm_a: assert property (
    (ext_mode and low_write_s) |=> (!pre_tick || !ext_mode) until ext_armed_reg)
    else $error("external count before a falling edge");

  osc_pins_a: assert property (
    osc_en |-> (osc_pin_read == 2'b00 && osc_pin_oe_n == 2'b11))
    else $error("oscillator pins not forced to inputs");

  buffer_latch_a: assert property (
    (wide && rd_low) |=> high_buf_reg == $past(count_reg[15:8]))
    else $error("high byte not latched on low read");

  prescale_clear_a: assert property (
    low_write_s |=> pre_reg == 3'h0)
    else $error("low write left prescaler count");

  wrap_flag_a: assert property (
    wrap |=> (count_reg == 16'h0000 && flag_reg))
    else $error("wrap did not clear count and set flag");

  trigger_reset_a: assert property (
    trig_reset |=> count_reg == 16'h0000)
    else $error("special event did not clear count");

  pulse_done_a: assert property (
    (pulse_open && gate_fall && gcfg_reg.gate_single_pulse_mode) |=> !pulse_go)
    else $error("single pulse did not finish on closing edge");

endmodule

// file: verification/tcg_far_model.sv
/*
  Far-side model of the timer: external count pin and crystal oscillator.
  Assumes the bench raises run for whole pulse trains on the system clock.
*/
module tcg_far_model (
  // Clock
  input  wire logic clock,
  // Control from bench
  input  wire logic run,
  input  wire logic sel_osc,
  // Pins towards the timer
  output logic      external_count_pin,
  output logic      osc_input_pin,
  output logic      osc_output_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase_reg = 2'h0;
  logic       wave_reg  = 1'b0;

  initial external_count_pin = 1'b0;
  initial osc_input_pin = 1'b0;
  initial osc_output_pin = 1'b0;

  // Wave toggles every third cycle; the first rise of a train has no fall before it
  always @(posedge clock) begin
    if (!run) begin
      phase_reg <= 2'h0;
      wave_reg  <= 1'b0;
    end else if (phase_reg == 2'h2) begin
      phase_reg <= 2'h0;
      wave_reg  <= ~wave_reg;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  always @(posedge clock) begin
    external_count_pin <= sel_osc ? 1'b0 : wave_reg;
    osc_input_pin      <= sel_osc ? wave_reg : 1'b0;
    // Amplifier output is undriven when idle, so it wanders
    osc_output_pin     <= (sel_osc && run) ? ~wave_reg : ~osc_output_pin;
  end
endmodule

// file: verification/tcg_timer_tb.sv
/*
  Self-checking bench of the gated timer: APB master tasks and scenarios.
  Assumes zero-wait APB with byte offsets from the package.
*/
module tcg_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock   = 1'b0;
  logic        nrst    = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        last_err;
  logic [3:0]  gsrc    = 4'h0;
  logic        trig    = 1'b0;
  logic        run     = 1'b0;
  logic        sel_osc = 1'b0;
  logic        ext_pin;
  logic        osc_in;
  logic        osc_out;
  logic [1:0]  oe_n;
  logic [1:0]  pin_rd;
  logic        amp_en;
  logic        irq;
  int          n_fail    = 0;
  int          cmp_count = 0;

  localparam logic [7:0] CTL = tcg_pkg::TCG_OFF_CONTROL;
  localparam logic [7:0] GAT = tcg_pkg::TCG_OFF_GATE;
  localparam logic [7:0] LOW = tcg_pkg::TCG_OFF_LOW;
  localparam logic [7:0] HIG = tcg_pkg::TCG_OFF_HIGH;
  localparam logic [7:0] STA = tcg_pkg::TCG_OFF_STATUS;

  initial forever #5 clock = ~clock;

  tcg_timer u_tcg_timer (
    .clock(clock), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_pin(ext_pin), .osc_input_pin(osc_in),
    .osc_output_pin(osc_out), .gate_pin(gsrc[0]), .osc_pin_oe_n(oe_n),
    .osc_pin_read(pin_rd), .osc_amp_enable(amp_en),
    .companion_period_match(gsrc[1]), .comparator1_out(gsrc[2]),
    .comparator2_out(gsrc[3]), .special_event_trigger(trig),
    .port_direction_bits(2'b01), .overflow_irq(irq)
  );

  tcg_far_model u_tcg_far_model (
    .clock(clock), .run(run), .sel_osc(sel_osc), .external_count_pin(ext_pin),
    .osc_input_pin(osc_in), .osc_output_pin(osc_out)
  );

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  // One full transfer; holds everything until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clock);
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel <= 1'b1;
    @(posedge clock);
    penable <= 1'b1;
    // Answer is looked at mid-cycle, where it stands for the taking edge
    @(negedge clock);
    while (pready !== 1'b1)
      @(negedge clock);
    q = prdata[7:0];
    last_err = pslverr;
    @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(a, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    apb(a, 1'b0, 8'h00, q);
  endtask

  // Low byte advance over exactly 64 clock cycles
  task automatic rate(output logic [7:0] d);
    logic [7:0] a0;
    logic [7:0] a1;
    rd(LOW, a0);
    repeat (61) @(posedge clock);
    rd(LOW, a1);
    d = a1 - a0;
  endtask

  task automatic t_reset();
    logic [7:0] q;
    rd(CTL, q);
    chk(q, tcg_pkg::TCG_CONTROL_RESET);
    rd(GAT, q);
    chk(q & 8'hfb, tcg_pkg::TCG_GATE_RESET);
    rd(STA, q);
    chk(q, 8'h00);
    rd(8'h14, q);
    chk(q, 8'h00);
    chk({7'h0, last_err}, 8'h01);
  endtask

  task automatic t_rate();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      // Sync bit set on purpose: internal sources must ignore it
      wr(CTL, {1'b0, i[2], i[1:0], 4'b0101});
      rate(d);
      chk(d, 8'(64 >> (i[1:0] + (i[2] ? 0 : 2))));
    end
    wr(CTL, 8'h40);
    rate(d);
    chk(d, 8'h00);
  endtask

  task automatic t_gate();
    logic [7:0] d;
    logic [7:0] q;
    wr(GAT, 8'h80);
    wr(CTL, 8'h41);
    for (int i = 0; i < 16; i++) begin
      gsrc <= {4{~i[0]}} ^ (4'b0001 << i[3:2]);
      wr(GAT, {1'b1, i[1], 4'b0000, i[3:2]});
      repeat (4) @(posedge clock);
      rate(d);
      chk(d, (i[0] == i[1]) ? 8'h40 : 8'h00);
      rd(GAT, q);
      chk({7'h0, q[2]}, {7'h0, i[0] == i[1]});
    end
    wr(GAT, 8'h00);
    rate(d);
    chk(d, 8'h40);
  endtask

  task automatic pulse_gate();
    gsrc <= 4'h1;
    repeat (4) @(posedge clock);
    gsrc <= 4'h0;
    repeat (4) @(posedge clock);
  endtask

  task automatic t_toggle();
    logic [7:0] q;
    gsrc <= 4'h0;
    wr(GAT, 8'h60);
    for (int i = 1; i < 4; i++) begin
      pulse_gate();
      rd(GAT, q);
      chk({7'h0, q[2]}, {7'h0, i[0]});
    end
    wr(GAT, 8'h40);
    wr(GAT, 8'h60);
    rd(GAT, q);
    chk({7'h0, q[2]}, 8'h00);
  endtask

  task automatic t_pulse();
    logic [7:0] d;
    logic [7:0] q;
    wr(GAT, 8'hd0);
    wr(GAT, 8'hd8);
    rd(GAT, q);
    chk({7'h0, q[3]}, 8'h01);
    rate(d);
    chk(d, 8'h00);
    gsrc <= 4'h1;
    repeat (4) @(posedge clock);
    rate(d);
    chk(d, 8'h40);
    gsrc <= 4'h0;
    repeat (4) @(posedge clock);
    rd(GAT, q);
    chk({7'h0, q[3]}, 8'h00);
    rate(d);
    chk(d, 8'h00);
    wr(GAT, 8'hd8);
    wr(GAT, 8'hc0);
    rd(GAT, q);
    chk({7'h0, q[3]}, 8'h00);
  endtask

  task automatic t_wide();
    logic [7:0] q;
    wr(GAT, 8'h00);
    wr(CTL, 8'h02);
    wr(HIG, 8'h12);
    wr(LOW, 8'h34);
    rd(LOW, q);
    chk(q, 8'h34);
    rd(HIG, q);
    chk(q, 8'h12);
    wr(HIG, 8'hab);
    wr(CTL, 8'h00);
    rd(HIG, q);
    chk(q, 8'h12);
    wr(HIG, 8'h56);
    rd(HIG, q);
    chk(q, 8'h56);
  endtask

  task automatic t_ovf();
    logic [7:0] q;
    wr(STA, 8'h02);
    wr(CTL, 8'h02);
    wr(HIG, 8'hff);
    wr(LOW, 8'hf0);
    wr(CTL, 8'h43);
    repeat (20) @(posedge clock);
    chk({7'h0, irq}, 8'h01);
    wr(CTL, 8'h42);
    rd(LOW, q);
    rd(HIG, q);
    chk(q, 8'h00);
    rd(STA, q);
    chk(q, 8'h03);
    wr(STA, 8'h03);
    rd(STA, q);
    chk(q, 8'h02);
    chk({7'h0, irq}, 8'h00);
  endtask

  task automatic t_ext();
    logic [7:0] a0;
    logic [7:0] a1;
    for (int m = 0; m < 3; m++) begin
      sel_osc <= (m == 2);
      wr(CTL, {4'h8, m == 2, m == 1, 2'b00});
      wr(CTL, {4'h8, m == 2, m == 1, 2'b01});
      wr(LOW, 8'h00);
      a0 = 8'h00;
      if (m == 2) begin
        chk({6'h0, oe_n}, 8'h03);
        chk({6'h0, pin_rd}, 8'h00);
        chk({7'h0, amp_en}, 8'h01);
      end
      run <= 1'b1;
      repeat (60) @(posedge clock);
      run <= 1'b0;
      repeat (8) @(posedge clock);
      rd(LOW, a1);
      // First rise after the count write lacks a preceding fall
      chk(a1 - a0, 8'h09);
    end
    wr(CTL, 8'h00);
    @(posedge clock);
    chk({7'h0, amp_en}, 8'h00);
    chk({6'h0, oe_n}, 8'h01);
  endtask

  task automatic t_trig();
    logic [7:0] q;
    wr(LOW, 8'h77);
    @(posedge clock);
    trig <= 1'b1;
    @(posedge clock);
    trig <= 1'b0;
    rd(LOW, q);
    chk(q, 8'h00);
  endtask

  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_rate();
    // Gate test programs the gate register before the control register
    t_gate();
    t_toggle();
    t_pulse();
    t_wide();
    t_ovf();
    t_ext();
    t_trig();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    conclude();
  end
endmodule
